//--- nicm_core.sv
// Interrupt cause, mask, auto-clear and throttle aggregation core
`timescale 1ns/1ps

// Summary of operation
// - Interrupts reach the host as a legacy level or as MSI pulses.
// - Each event source drives a fixed cause bit; sources may share bits.
// - Legacy and MSI interrupt only while some cause bit and its mask bit are both one.
// - Cause bits record events whatever the mask holds.
// - Writing ones to the force register sets those cause bits.
// - Mask-set write sets mask bits written as one, others unchanged.
// - Mask-clear write clears mask bits written as one.
// - Reading the mask-set register returns the current mask.
// - Auto-clear bits 24..20 clear cause and mask bits after an interrupt.
// - Auto-mask bits set mask bits on a write-one-to-clear of cause.
// - Summary other-cause bit set whenever a legacy indication bit is set.
// - One timer enforces a minimum interval between interrupts, in 13-cycle (260 ns) units.
// - Interrupt rate never exceeds 7813 per second.
// - Throttle interval register is zero after reset.
// - Cause write clears bits written one, keeps bits written zero.
// - Any read of the cause register clears all its bits.
module nicm_core (
  input  wire logic                        sys_clk_in,
  input  wire logic                        rst_b_in,
  input  wire logic                        clk_en_in,
  input  wire logic [nicm_pkg::ADDR_W-1:0] reg_addr_in,
  input  wire logic [nicm_pkg::DATA_W-1:0] reg_wdata_in,
  input  wire logic                        reg_wr_in,
  input  wire logic                        reg_rd_in,
  input  wire logic [nicm_pkg::DATA_W-1:0] evt_in,
  input  wire logic                        link_state_change_event_in,
  input  wire logic                        phy_management_access_complete_in,
  output logic [nicm_pkg::DATA_W-1:0]      reg_rdata_out,
  output logic                             legacy_int_out,
  output logic                             msi_req_out,
  output logic                             irq_out
);
  import nicm_pkg::*;

  logic [DATA_W-1:0] interrupt_cause_ff;
  logic [DATA_W-1:0] interrupt_mask_ff;
  logic [DATA_W-1:0] interrupt_auto_clear_enable_ff;
  logic [DATA_W-1:0] interrupt_auto_mask_enable_ff;
  logic [THR_W-1:0]  interrupt_throttle_interval_ff;
  logic              msi_mode_ff;
  logic [1:0]        bstat_ff;
  logic [1:0]        bmask_ff;
  logic              active_ff;

  logic [DATA_W-1:0] nxt_cause;
  logic [DATA_W-1:0] nxt_mask;
  logic [DATA_W-1:0] hw_set;
  logic [DATA_W-1:0] rdata_mux;
  logic              pending;
  logic              expired;
  logic              fire;
  logic              deferred;

  function automatic logic hit(input logic [ADDR_W-1:0] off, input logic stb);
    hit = stb && (reg_addr_in == off);
  endfunction

  logic wr_cause;
  logic wr_force;
  logic wr_mset;
  logic wr_mclr;
  logic rd_cause;
  logic rd_bstat;

  assign wr_cause = hit(OFF_CAUSE, reg_wr_in);
  assign wr_force = hit(OFF_FORCE, reg_wr_in);
  assign wr_mset  = hit(OFF_MSET, reg_wr_in);
  assign wr_mclr  = hit(OFF_MCLR, reg_wr_in);
  assign rd_cause = hit(OFF_CAUSE, reg_rd_in);
  assign rd_bstat = hit(OFF_BSTAT, reg_rd_in);

  // Fixed source-to-bit map; link and management events share bits with evt_in
  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++) begin : g_map
      if (gi == LSC_BIT) begin : g_lsc
        assign hw_set[gi] = evt_in[gi] | link_state_change_event_in;
      end else if (gi == MDIO_BIT) begin : g_mdio
        assign hw_set[gi] = evt_in[gi] | phy_management_access_complete_in;
      end else begin : g_plain
        assign hw_set[gi] = evt_in[gi];
      end
    end
  endgenerate

  assign pending  = |(interrupt_cause_ff & interrupt_mask_ff);
  // New interrupt only when none is outstanding and the interval has run out
  assign fire     = pending && expired && !active_ff;
  assign deferred = pending && !expired && !active_ff;

  nicm_throttle u_throttle (
    .sys_clk_in  (sys_clk_in),
    .rst_b_in    (rst_b_in),
    .clk_en_in   (clk_en_in),
    .fire_in     (fire),
    .interval_in (interrupt_throttle_interval_ff),
    .expired_out (expired)
  );

  always_comb begin
    nxt_cause = interrupt_cause_ff;
    if (rd_cause) begin
      nxt_cause = ZERO_W;
    end else if (wr_cause) begin
      nxt_cause = nxt_cause & ~reg_wdata_in;
    end
    if (fire) begin
      nxt_cause = nxt_cause & ~(interrupt_auto_clear_enable_ff & AUTOCLR_FIELD);
    end
    if (wr_force) begin
      nxt_cause = nxt_cause | reg_wdata_in;
    end
    // Set applied last so a same-cycle clear cannot lose an event
    nxt_cause = nxt_cause | hw_set;
    nxt_cause[OTHER_BIT] = nxt_cause[OTHER_BIT] | (|(nxt_cause & LEGACY_MASK));
  end

  always_comb begin
    nxt_mask = interrupt_mask_ff;
    if (wr_mset) begin
      nxt_mask = nxt_mask | reg_wdata_in;
    end
    if (wr_mclr) begin
      nxt_mask = nxt_mask & ~reg_wdata_in;
    end
    if (wr_cause) begin
      nxt_mask = nxt_mask | (reg_wdata_in & interrupt_auto_mask_enable_ff);
    end
    if (fire) begin
      nxt_mask = nxt_mask & ~(interrupt_auto_clear_enable_ff & AUTOCLR_FIELD);
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      interrupt_cause_ff <= ZERO_W;
    end else if (clk_en_in) begin
      interrupt_cause_ff <= nxt_cause;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      interrupt_mask_ff <= ZERO_W;
    end else if (clk_en_in) begin
      interrupt_mask_ff <= nxt_mask;
    end
  end

  // Plain read/write configuration
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      interrupt_auto_clear_enable_ff <= ZERO_W;
      interrupt_auto_mask_enable_ff  <= ZERO_W;
      interrupt_throttle_interval_ff <= THR_RESET;
      msi_mode_ff                    <= 1'b0;
      bmask_ff                       <= BST_ZERO;
    end else if (clk_en_in) begin
      if (hit(OFF_AUTOCLR, reg_wr_in)) begin
        interrupt_auto_clear_enable_ff <= reg_wdata_in & AUTOCLR_FIELD;
      end
      if (hit(OFF_AUTOMASK, reg_wr_in)) begin
        interrupt_auto_mask_enable_ff <= reg_wdata_in;
      end
      if (hit(OFF_THROTTLE, reg_wr_in)) begin
        interrupt_throttle_interval_ff <= reg_wdata_in[THR_W-1:0];
      end
      if (hit(OFF_MODE, reg_wr_in)) begin
        msi_mode_ff <= reg_wdata_in[MODE_MSI_BIT];
      end
      if (hit(OFF_BMASK, reg_wr_in)) begin
        bmask_ff <= reg_wdata_in[1:0];
      end
    end
  end

  // Outstanding interrupt lasts until no unmasked cause remains
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      active_ff <= 1'b0;
    end else if (clk_en_in) begin
      if (fire) begin
        active_ff <= 1'b1;
      end else if (!pending) begin
        active_ff <= 1'b0;
      end
    end
  end

  // Delivery: level for legacy, one pulse per interrupt for MSI
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      legacy_int_out <= 1'b0;
      msi_req_out    <= 1'b0;
    end else if (clk_en_in) begin
      legacy_int_out <= !msi_mode_ff && pending && (active_ff || fire);
      msi_req_out    <= msi_mode_ff && fire;
    end
  end

  // Block event status, cleared on read; set wins over the read clear
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bstat_ff <= BST_ZERO;
    end else if (clk_en_in) begin
      bstat_ff[BST_FIRED] <= fire || (bstat_ff[BST_FIRED] && !rd_bstat);
      bstat_ff[BST_DEFER] <= deferred || (bstat_ff[BST_DEFER] && !rd_bstat);
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_out <= 1'b0;
    end else if (clk_en_in) begin
      irq_out <= |(bstat_ff & bmask_ff);
    end
  end

  always_comb begin
    case (reg_addr_in)
      OFF_CAUSE:    rdata_mux = interrupt_cause_ff;
      OFF_MSET:     rdata_mux = interrupt_mask_ff;
      OFF_AUTOCLR:  rdata_mux = interrupt_auto_clear_enable_ff;
      OFF_AUTOMASK: rdata_mux = interrupt_auto_mask_enable_ff;
      OFF_THROTTLE: rdata_mux = {{(DATA_W-THR_W){1'b0}}, interrupt_throttle_interval_ff};
      OFF_MODE:     rdata_mux = {{(DATA_W-1){1'b0}}, msi_mode_ff};
      OFF_BSTAT:    rdata_mux = {{(DATA_W-2){1'b0}}, bstat_ff};
      OFF_BMASK:    rdata_mux = {{(DATA_W-2){1'b0}}, bmask_ff};
      default:      rdata_mux = ZERO_W;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= ZERO_W;
    end else if (clk_en_in) begin
      reg_rdata_out <= reg_rd_in ? rdata_mux : ZERO_W;
    end
  end

  // Cycles since the last interrupt; saturates so long intervals need no wide counter
  localparam int               GAP_W   = THR_W + PRESC_W;
  localparam int               GAP_MIN = int'(MIN_INTERVAL) * int'(THR_UNIT_CYC) - 1;
  localparam logic [GAP_W-1:0] GAP_ONE = GAP_W'(1);
  logic [GAP_W-1:0]            gap_cnt_ff;

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      gap_cnt_ff <= '1;
    end else if (clk_en_in) begin
      if (fire) begin
        gap_cnt_ff <= '0;
      end else if (gap_cnt_ff != '1) begin
        gap_cnt_ff <= gap_cnt_ff + GAP_ONE;
      end
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);

  a_gate_by_mask: assert property (legacy_int_out |-> $past(pending))
    else $error("legacy interrupt without unmasked cause");

  a_msi_by_mask: assert property ($past(clk_en_in) && msi_req_out |-> $past(pending))
    else $error("message interrupt without unmasked cause");

  a_msi_pulse: assert property (clk_en_in && msi_req_out |=> !msi_req_out)
    else $error("message request longer than one cycle");

  a_cause_capture: assert property (clk_en_in && |hw_set |=>
    (interrupt_cause_ff & $past(hw_set)) == $past(hw_set))
    else $error("event not recorded in cause");

  a_event_wins: assert property (clk_en_in && (rd_cause || wr_cause) && |hw_set |=>
    (interrupt_cause_ff & $past(hw_set)) != ZERO_W)
    else $error("event lost under clear");

  a_force_sets: assert property (clk_en_in && wr_force |=>
    (interrupt_cause_ff & $past(reg_wdata_in)) == $past(reg_wdata_in))
    else $error("force did not set cause");

  a_mask_set: assert property (clk_en_in && wr_mset && !fire |=>
    interrupt_mask_ff == ($past(interrupt_mask_ff) | $past(reg_wdata_in)))
    else $error("mask set wrong");

  a_mask_clear: assert property (clk_en_in && wr_mclr |=>
    (interrupt_mask_ff & $past(reg_wdata_in)) == ZERO_W)
    else $error("mask clear wrong");

  a_mask_read: assert property (clk_en_in && hit(OFF_MSET, reg_rd_in) |=>
    reg_rdata_out == $past(interrupt_mask_ff))
    else $error("mask read wrong");

  a_rdata_idle: assert property (clk_en_in && !reg_rd_in |=> reg_rdata_out == ZERO_W)
    else $error("read data outside its cycle");

  a_auto_clear: assert property (clk_en_in && fire |=>
    (interrupt_cause_ff & $past(interrupt_auto_clear_enable_ff & AUTOCLR_FIELD & ~hw_set
    & ~(wr_force ? reg_wdata_in : ZERO_W) & ~LEGACY_MASK)) == ZERO_W)
    else $error("auto clear missed");

  a_auto_mask: assert property (clk_en_in && wr_cause && !fire |=>
    (interrupt_mask_ff & $past(reg_wdata_in & interrupt_auto_mask_enable_ff))
    == $past(reg_wdata_in & interrupt_auto_mask_enable_ff))
    else $error("auto mask missed");

  a_other_cause: assert property (|(interrupt_cause_ff & LEGACY_MASK) |->
    interrupt_cause_ff[OTHER_BIT])
    else $error("other cause bit missing");

  a_throttle_gap: assert property (clk_en_in && fire |=> !fire [*8])
    else $error("interrupts too close");

  // Counter check catches a broken timer that the short window above would miss
  a_min_gap: assert property (clk_en_in && fire |-> gap_cnt_ff >= GAP_MIN)
    else $error("interval between interrupts too short");

  a_write_clear: assert property (clk_en_in && wr_cause |=>
    (interrupt_cause_ff & $past(reg_wdata_in & ~hw_set) & ~LEGACY_MASK
    & ~(ZERO_W | (32'h1 << OTHER_BIT))) == ZERO_W)
    else $error("write clear failed");

  a_read_clear: assert property (clk_en_in && rd_cause |=>
    (interrupt_cause_ff & ~$past(hw_set) & ~LEGACY_MASK & ~(32'h1 << OTHER_BIT)) == ZERO_W)
    else $error("read clear failed");

  a_freeze_state: assert property (!clk_en_in |=>
    $stable(interrupt_cause_ff) && $stable(interrupt_mask_ff))
    else $error("state moved while clock enable low");

  a_fire_at_once: assert property (clk_en_in && fire && !msi_mode_ff |=> legacy_int_out)
    else $error("immediate interrupt missing");

  c_legacy_fire: cover property (fire && !msi_mode_ff);
  c_msi_fire:    cover property (msi_req_out);
  c_deferred:    cover property (deferred ##1 fire);
  c_auto_mask:   cover property (wr_cause && |interrupt_auto_mask_enable_ff);
endmodule // nicm_core

//--- nicm_throttle.sv
// Shared constants and the inter-interrupt throttle timer
`timescale 1ns/1ps

package nicm_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam int          THR_W         = 16;
  localparam int          PRESC_W       = 4;

  localparam logic [7:0]  OFF_CAUSE     = 8'h00;
  localparam logic [7:0]  OFF_FORCE     = 8'h04;
  localparam logic [7:0]  OFF_MSET      = 8'h08;
  localparam logic [7:0]  OFF_MCLR      = 8'h0C;
  localparam logic [7:0]  OFF_AUTOCLR   = 8'h10;
  localparam logic [7:0]  OFF_AUTOMASK  = 8'h14;
  localparam logic [7:0]  OFF_THROTTLE  = 8'h18;
  localparam logic [7:0]  OFF_MODE      = 8'h1C;
  localparam logic [7:0]  OFF_BSTAT     = 8'h20;
  localparam logic [7:0]  OFF_BMASK     = 8'h24;

  localparam logic [31:0] ZERO_W        = 32'h0000_0000;
  localparam logic [31:0] AUTOCLR_FIELD = 32'h01F0_0000;
  localparam int          LSC_BIT       = 2;
  localparam int          MDIO_BIT      = 9;
  localparam int          OTHER_BIT     = 31;
  localparam logic [31:0] LEGACY_MASK   = 32'h0000_0204;

  localparam int          MODE_MSI_BIT  = 0;
  localparam int          BST_FIRED     = 0;
  localparam int          BST_DEFER     = 1;
  localparam logic [1:0]  BST_ZERO      = 2'h0;

  localparam logic [THR_W-1:0] THR_RESET = 16'h0000;
  localparam int          CLK_NS        = 20;
  localparam int          THR_UNIT_NS   = 256;
  localparam int          MAX_RATE      = 7813;
  localparam logic [PRESC_W-1:0] THR_UNIT_CYC =
    PRESC_W'((THR_UNIT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [THR_W-1:0] MIN_INTERVAL =
    THR_W'((1000000000 + THR_UNIT_NS * MAX_RATE - 1) / (THR_UNIT_NS * MAX_RATE));
  localparam logic [PRESC_W-1:0] PRESC_ONE = 4'h1;
  localparam logic [THR_W-1:0]   THR_ONE   = 16'h0001;
endpackage

module nicm_throttle (
  input  wire logic                      sys_clk_in,
  input  wire logic                      rst_b_in,
  input  wire logic                      clk_en_in,
  input  wire logic                      fire_in,
  input  wire logic [nicm_pkg::THR_W-1:0] interval_in,
  output logic                           expired_out
);
  import nicm_pkg::*;

  logic [THR_W-1:0]   units_ff;
  logic [PRESC_W-1:0] presc_ff;
  logic [THR_W-1:0]   eff_interval;

  // Floor on the interval caps the rate even with a zero setting
  assign eff_interval = (interval_in < MIN_INTERVAL) ? MIN_INTERVAL : interval_in;

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      units_ff <= THR_RESET;
      presc_ff <= THR_UNIT_CYC;
    end else if (clk_en_in) begin
      if (fire_in) begin
        units_ff <= eff_interval;
        presc_ff <= THR_UNIT_CYC;
      end else if (units_ff != THR_RESET) begin
        if (presc_ff == PRESC_ONE) begin
          presc_ff <= THR_UNIT_CYC;
          units_ff <= units_ff - THR_ONE;
        end else begin
          presc_ff <= presc_ff - PRESC_ONE;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      expired_out <= 1'b1;
    end else if (clk_en_in) begin
      expired_out <= !fire_in && (units_ff == THR_RESET ||
                     (units_ff == THR_ONE && presc_ff == PRESC_ONE));
    end
  end
endmodule // nicm_throttle

//--- nicm_host_model.sv
// Host-side model that receives legacy and message interrupts
`timescale 1ns/1ps
module nicm_host_model (
  input  wire logic sys_clk_in,
  input  wire logic rst_b_in,
  input  wire logic legacy_int_in,
  input  wire logic msi_req_in,
  output int        int_count_out,
  output int        gap_out
);
  logic legacy_q_ff;
  int   since_ff;

  // A level rise or one pulse is one delivery; gap is in cycles
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      legacy_q_ff   <= 1'b0;
      int_count_out <= 0;
      gap_out       <= 0;
      since_ff      <= 0;
    end else begin
      legacy_q_ff <= legacy_int_in;
      since_ff    <= since_ff + 1;
      if (msi_req_in || (legacy_int_in && !legacy_q_ff)) begin
        int_count_out <= int_count_out + 1;
        gap_out       <= since_ff + 1;
        since_ff      <= 0;
      end
    end
  end
endmodule // nicm_host_model

//--- nicm_core_tb.sv
// Self-checking bench for the interrupt cause, mask and throttle core
`timescale 1ns/1ps
module nicm_core_tb;
  import nicm_pkg::*;
  logic              sys_clk_in;
  logic              rst_b_in;
  logic              clk_en_in;
  logic [ADDR_W-1:0] reg_addr_in;
  logic [DATA_W-1:0] reg_wdata_in;
  logic              reg_wr_in;
  logic              reg_rd_in;
  logic [DATA_W-1:0] evt_in;
  logic              link_evt;
  logic              mgmt_evt;
  logic [DATA_W-1:0] reg_rdata_out;
  logic              legacy_int_out;
  logic              msi_req_out;
  logic              irq_out;
  int                int_count;
  int                gap;
  int                fail_count;
  int                cmp_count;
  logic [31:0]       rdq;
  logic [31:0]       m_cause;
  logic [31:0]       m_mask;
  logic [31:0]       m_am;
  logic [31:0]       r;
  int                iv_q[$];

  nicm_core dut_u (
    .sys_clk_in                        (sys_clk_in),
    .rst_b_in                          (rst_b_in),
    .clk_en_in                         (clk_en_in),
    .reg_addr_in                       (reg_addr_in),
    .reg_wdata_in                      (reg_wdata_in),
    .reg_wr_in                         (reg_wr_in),
    .reg_rd_in                         (reg_rd_in),
    .evt_in                            (evt_in),
    .link_state_change_event_in        (link_evt),
    .phy_management_access_complete_in (mgmt_evt),
    .reg_rdata_out                     (reg_rdata_out),
    .legacy_int_out                    (legacy_int_out),
    .msi_req_out                       (msi_req_out),
    .irq_out                           (irq_out)
  );

  nicm_host_model host_u (
    .sys_clk_in    (sys_clk_in),
    .rst_b_in      (rst_b_in),
    .legacy_int_in (legacy_int_out),
    .msi_req_in    (msi_req_out),
    .int_count_out (int_count),
    .gap_out       (gap)
  );

  initial begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int got);
    cmp_count++;
    if (got < lo || got > lo + 3) begin
      fail_count++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, lo + 3, got);
    end
  endtask

  // Strobes stay up between ops so back-to-back ops run in consecutive cycles with no idle cycle between
  task automatic op(input logic w, input logic [7:0] a, input logic [31:0] d);
    reg_wr_in    <= w;
    reg_rd_in    <= !w;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge sys_clk_in);
    #1;
    rdq = reg_rdata_out;
  endtask

  task automatic idle(input int n);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    op(1'b1, a, d);
    case (a)
      OFF_FORCE:    m_cause |= d;
      OFF_MSET:     m_mask |= d;
      OFF_MCLR:     m_mask &= ~d;
      OFF_AUTOMASK: m_am = d;
      OFF_CAUSE: begin
        m_cause &= ~d;
        m_mask  |= d & m_am;
      end
      default: ;
    endcase
    m_cause[31] |= m_cause[2] | m_cause[9];
  endtask

  task automatic rd(input logic [7:0] a, input string nm, input logic [31:0] e);
    op(1'b0, a, ZERO_W);
    chk(nm, e, rdq);
  endtask

  task automatic rdc();
    op(1'b0, OFF_CAUSE, ZERO_W);
    chk("cause", m_cause, rdq);
    m_cause = ZERO_W;
  endtask

  task automatic evt(input logic [31:0] v, input logic l, input logic p);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    evt_in    <= v;
    link_evt  <= l;
    mgmt_evt  <= p;
    @(posedge sys_clk_in);
    #1;
    evt_in   <= ZERO_W;
    link_evt <= 1'b0;
    mgmt_evt <= 1'b0;
    m_cause |= v | {22'h0, p, 6'h0, l, 2'h0};
    m_cause[31] |= m_cause[2] | m_cause[9];
  endtask

  // Bounded wait for one more delivery at the host
  task automatic wait_int(input int n);
    int c0;
    c0 = int_count;
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    for (int i = 0; i < n && int_count == c0; i++) begin
      @(posedge sys_clk_in);
      #1;
    end
    chk("interrupt count", 32'(c0 + 1), 32'(int_count));
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Longest path is about 30k cycles of throttle waits
  initial begin
    repeat (50000) @(posedge sys_clk_in);
    fail_count++;
    report_and_stop();
  end

  initial begin
    rst_b_in     = 1'b0;
    clk_en_in    = 1'b1;
    reg_addr_in  = '0;
    reg_wdata_in = ZERO_W;
    reg_wr_in    = 1'b0;
    reg_rd_in    = 1'b0;
    evt_in       = ZERO_W;
    link_evt     = 1'b0;
    mgmt_evt     = 1'b0;
    m_cause      = ZERO_W;
    m_mask       = ZERO_W;
    m_am         = ZERO_W;
    void'($urandom(32'hC0AAED9B));
    repeat (3) @(posedge sys_clk_in);
    #1 rst_b_in = 1'b1;
    for (int i = 0; i < 11; i++) begin
      rd(8'(4 * i), "reset value", ZERO_W);
    end
    $display("test reset done");
    r = $urandom;
    wr(OFF_MSET, r);
    rd(OFF_MSET, "mask", m_mask);
    wr(OFF_MCLR, $urandom);
    rd(OFF_MSET, "mask", m_mask);
    wr(8'h3C, $urandom);
    rd(OFF_MCLR, "mask clear", ZERO_W);
    rd(OFF_MSET, "mask", m_mask);
    wr(OFF_MCLR, 32'hFFFF_FFFF);
    $display("test mask done");
    wr(OFF_FORCE, $urandom);
    idle(3);
    chk("legacy masked", ZERO_W, 32'(legacy_int_out));
    wr(OFF_CAUSE, $urandom);
    rdc();
    rdc();
    evt($urandom, 1'b0, 1'b0);
    rdc();
    evt(ZERO_W, 1'b1, 1'b0);
    rdc();
    evt(ZERO_W, 1'b0, 1'b1);
    rdc();
    evt_in <= 32'h0000_0080;
    rdc();
    evt_in <= ZERO_W;
    m_cause = 32'h0000_0080;
    rdc();
    $display("test cause done");
    r = $urandom & 32'h7FFF_FFFF;
    wr(OFF_AUTOMASK, r);
    rd(OFF_AUTOMASK, "auto mask", r);
    wr(OFF_FORCE, $urandom);
    wr(OFF_CAUSE, $urandom);
    rd(OFF_MSET, "mask", m_mask);
    wr(OFF_AUTOMASK, ZERO_W);
    wr(OFF_MCLR, 32'hFFFF_FFFF);
    rdc();
    $display("test auto mask done");
    r = $urandom | 32'h0020_0000;
    wr(OFF_AUTOCLR, r);
    rd(OFF_AUTOCLR, "auto clear", r & AUTOCLR_FIELD);
    wr(OFF_BMASK, 32'h0000_0001);
    wr(OFF_MSET, 32'h0020_0000);
    evt(32'h0020_0000, 1'b0, 1'b0);
    wait_int(6);
    m_cause[21] = 1'b0;
    m_mask[21]  = 1'b0;
    rd(OFF_MSET, "mask", m_mask);
    rdc();
    chk("legacy", ZERO_W, 32'(legacy_int_out));
    chk("irq", 32'h0000_0001, 32'(irq_out));
    rd(OFF_BSTAT, "block status", 32'h0000_0001);
    idle(2);
    chk("irq", ZERO_W, 32'(irq_out));
    $display("test legacy done");
    wr(OFF_MODE, 32'h0000_0001);
    wr(OFF_MSET, 32'h0000_0040);
    iv_q = '{100, 600};
    foreach (iv_q[k]) begin
      wr(OFF_THROTTLE, 32'(iv_q[k]));
      rd(OFF_THROTTLE, "interval", 32'(iv_q[k]));
      idle(8000);
      wr(OFF_FORCE, 32'h0000_0040);
      wait_int(6);
      chk("legacy", ZERO_W, 32'(legacy_int_out));
      rdc();
      wr(OFF_FORCE, 32'h0000_0040);
      wait_int(9000);
      chk_rng("gap", (iv_q[k] < 500 ? 500 : iv_q[k]) * 13, gap);
      rd(OFF_BSTAT, "block status", 32'h0000_0003);
      rdc();
      $display("test throttle %0d done", iv_q[k]);
    end
    // A write while the enable is low must leave the mask untouched
    clk_en_in <= 1'b0;
    op(1'b1, OFF_MSET, $urandom);
    clk_en_in <= 1'b1;
    rd(OFF_MSET, "mask frozen", m_mask);
    $display("test clock enable done");
    idle(1);
    report_and_stop();
  end
endmodule // nicm_core_tb
